// ==== src/spms_defines.svh ====
// register offsets, field positions and reset values of the serial port
`ifndef SPMS_DEFINES_SVH
`define SPMS_DEFINES_SVH

// ---------------------------------------------------------------
// register byte offsets (apb, one 32-bit word each)
// ---------------------------------------------------------------
`define SPMS_STAT_OFS 8'h00
`define SPMS_CON1_OFS 8'h04
`define SPMS_CON2_OFS 8'h08
`define SPMS_BUF_OFS 8'h0C

// ---------------------------------------------------------------
// serial_status_control fields
// ---------------------------------------------------------------
`define SPMS_EN_BIT 15
`define SPMS_SIDL_BIT 13
`define SPMS_OVF_BIT 6
`define SPMS_TBF_BIT 1
`define SPMS_RBF_BIT 0
`define SPMS_STAT_WMASK 16'hA000
`define SPMS_STAT_RST 16'h0000

// ---------------------------------------------------------------
// serial_control_first fields
// ---------------------------------------------------------------
`define SPMS_CLKDIS_BIT 12
`define SPMS_DODIS_BIT 11
`define SPMS_WIDE_BIT 10
`define SPMS_SMP_BIT 9
`define SPMS_CKE_BIT 8
`define SPMS_SLAVE_SELECT_ENABLE_BIT 7
`define SPMS_CPOL_BIT 6
`define SPMS_MST_BIT 5
`define SPMS_SEC_MSB 4
`define SPMS_SEC_LSB 2
`define SPMS_PRI_MSB 1
`define SPMS_PRI_LSB 0
`define SPMS_CON1_WMASK 16'h1FFF
`define SPMS_CON1_RST 16'h0000

// ---------------------------------------------------------------
// second control register (framed operation)
// ---------------------------------------------------------------
`define SPMS_FEN_BIT 15
`define SPMS_FDIR_BIT 14
`define SPMS_FPOL_BIT 13
`define SPMS_FDLY_BIT 1
`define SPMS_CON2_WMASK 16'hE002
`define SPMS_CON2_RST 16'h0000

// ---------------------------------------------------------------
// transfer lengths and divider figures
// ---------------------------------------------------------------
`define SPMS_BITS_WORD 5'h10
`define SPMS_BITS_BYTE 5'h08
`define SPMS_SEC_BASE 4'h8

`endif

// ==== src/spms_pkg.sv ====
// types shared by the serial port design
package spms_pkg;

  // pin drive towards the four-wire link
  typedef struct packed {
    logic sck_o;
    logic sck_oe;
    logic sdo_o;
    logic sdo_oe;
    logic ss_o;
    logic ss_oe;
  } spms_pin_out_t;

  // whole state of the port
  typedef struct packed {
    logic [15:0] stat;
    logic [15:0] con1;
    logic [15:0] con2;
    logic [15:0] txh;
    logic txf;
    logic [15:0] rxh;
    logic rxf;
    logic ovf;
    logic [15:0] sr;
    logic [15:0] rxs;
    logic sdo;
    logic sck;
    logic busy;
    logic pre;
    logic fs;
    logic armed;
    logic [5:0] half;
    logic [4:0] bitn;
    logic [9:0] divc;
    logic sck1;
    logic sck2;
    logic sckp;
    logic ss1;
    logic ss2;
    logic sdi1;
    logic sdi2;
    logic [31:0] prdata;
  } spms_state_t;

endpackage

// ==== src/spms_port.sv ====
// serial master/slave port with apb register access
`timescale 1ns/1ps
`include "spms_defines.svh"

module spms_port
  import spms_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // device power state
  input wire logic idle_mode,
  // serial link pins
  input wire logic sck_i,
  input wire logic sdi_i,
  input wire logic ss_n_i,
  output spms_pin_out_t link_out
);

  spms_state_t s_reg;
  spms_state_t s_next;

  logic apb_setup;
  logic apb_acc;
  logic mapped;
  logic [15:0] rd_val;
  logic en;
  logic run;
  logic master;
  logic cpol;
  logic cke;
  logic sample_phase;
  logic wide;
  logic slave_select_enable;
  logic fen;
  logic fdir;
  logic fpol;
  logic fdly;
  logic clkdis;
  logic dodis;
  logic [3:0] msb;
  logic [4:0] nbits;
  logic [5:0] last_half;
  logic [9:0] pri_div;
  logic [9:0] sec_div;
  logic [19:0] div_full;
  logic [9:0] div_val;
  logic lead;
  logic trail;
  logic chg;
  logic smp_ev;
  logic done;

  // ---------------------------------------------------------------
  // configuration decode
  // ---------------------------------------------------------------
  assign en = s_reg.stat[`SPMS_EN_BIT];
  assign run = en && !(idle_mode && s_reg.stat[`SPMS_SIDL_BIT]);
  assign master = s_reg.con1[`SPMS_MST_BIT];
  assign cpol = s_reg.con1[`SPMS_CPOL_BIT];
  assign fen = s_reg.con2[`SPMS_FEN_BIT];
  assign cke = s_reg.con1[`SPMS_CKE_BIT] && !fen;
  assign sample_phase = s_reg.con1[`SPMS_SMP_BIT];
  assign wide = s_reg.con1[`SPMS_WIDE_BIT];
  assign slave_select_enable = s_reg.con1[`SPMS_SLAVE_SELECT_ENABLE_BIT];
  assign fdir = s_reg.con2[`SPMS_FDIR_BIT];
  assign fpol = s_reg.con2[`SPMS_FPOL_BIT];
  assign fdly = s_reg.con2[`SPMS_FDLY_BIT];
  assign clkdis = s_reg.con1[`SPMS_CLKDIS_BIT];
  assign dodis = s_reg.con1[`SPMS_DODIS_BIT];

  // word length and top bit position
  assign nbits = wide ? `SPMS_BITS_WORD : `SPMS_BITS_BYTE;
  assign msb = wide ? 4'hF : 4'h7;
  assign last_half = {nbits, 1'b0};

  // two-stage prescaler, each tick is half a clock period
  assign pri_div = 10'h001 <<
    {~s_reg.con1[`SPMS_PRI_MSB:`SPMS_PRI_LSB], 1'b0};
  assign sec_div = {6'h00, `SPMS_SEC_BASE -
    {1'b0, s_reg.con1[`SPMS_SEC_MSB:`SPMS_SEC_LSB]}};
  assign div_full = pri_div * sec_div;
  assign div_val = div_full[9:0];

  // slave clock edges from synchronised pin
  assign lead = (s_reg.sck2 != cpol) && (s_reg.sckp == cpol);
  assign trail = (s_reg.sck2 == cpol) && (s_reg.sckp != cpol);

  // ---------------------------------------------------------------
  // apb decode and read mux
  // ---------------------------------------------------------------
  assign apb_setup = psel && !penable;
  assign apb_acc = psel && penable;
  assign pready = 1'b1;
  assign pslverr = apb_acc && !mapped;
  assign prdata = s_reg.prdata;

  // read value of the addressed register
  always_comb begin
    mapped = 1'b1;
    rd_val = 16'h0000;
    case (paddr)
      `SPMS_STAT_OFS: begin
        rd_val = s_reg.stat;
        rd_val[`SPMS_OVF_BIT] = s_reg.ovf;
        rd_val[`SPMS_TBF_BIT] = s_reg.txf;
        rd_val[`SPMS_RBF_BIT] = s_reg.rxf;
      end
      `SPMS_CON1_OFS: rd_val = s_reg.con1;
      `SPMS_CON2_OFS: rd_val = s_reg.con2;
      `SPMS_BUF_OFS: rd_val = s_reg.rxh;
      default: mapped = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    chg = 1'b0;
    smp_ev = 1'b0;
    done = 1'b0;
    // two-flop synchronisers on link pins
    s_next.sck1 = sck_i;
    s_next.sck2 = s_reg.sck1;
    s_next.sckp = s_reg.sck2;
    s_next.ss1 = ss_n_i;
    s_next.ss2 = s_reg.ss1;
    s_next.sdi1 = sdi_i;
    s_next.sdi2 = s_reg.sdi1;
    // read data captured in setup phase
    if (apb_setup) begin
      s_next.prdata = {16'h0000, rd_val};
    end
    // software clears, applied before hardware sets
    if (apb_acc && !pwrite && paddr == `SPMS_BUF_OFS) begin
      s_next.rxf = 1'b0;
    end
    if (apb_acc && pwrite && paddr == `SPMS_STAT_OFS &&
        !pwdata[`SPMS_OVF_BIT]) begin
      s_next.ovf = 1'b0;
    end
    // serial engine
    if (!en) begin
      s_next.busy = 1'b0;
      s_next.pre = 1'b0;
      s_next.fs = 1'b0;
      s_next.armed = 1'b0;
      s_next.half = 6'h00;
      s_next.bitn = 5'h00;
      s_next.divc = 10'h000;
      s_next.sck = cpol;
    end else if (run && master) begin
      if (!s_reg.busy) begin
        s_next.sck = cpol;
        // start only with data loaded and clock allowed
        if (s_reg.txf && !clkdis) begin
          s_next.busy = 1'b1;
          s_next.txf = 1'b0;
          s_next.half = 6'h00;
          s_next.divc = 10'h000;
          s_next.sr = cke ? {s_reg.txh[14:0], 1'b0} : s_reg.txh;
          if (cke) begin
            s_next.sdo = s_reg.txh[msb];
          end
          s_next.fs = fen && !fdir;
          s_next.pre = fen && !fdir && !fdly;
        end
      end else if (s_reg.divc == div_val - 10'h001) begin
        s_next.divc = 10'h000;
        if (s_reg.pre) begin
          // sync pulse one half period long, ending half a period before first clock
          s_next.pre = 1'b0;
          s_next.fs = 1'b0;
        end else if (s_reg.half < last_half) begin
          s_next.sck = ~s_reg.sck;
          s_next.half = s_reg.half + 6'h01;
          if (!s_reg.half[0]) begin
            // idle to active edge
            chg = !cke;
            smp_ev = cke ? !sample_phase : (sample_phase && s_reg.half != 6'h00);
          end else begin
            // active to idle edge
            chg = cke && (s_reg.half != last_half - 6'h01);
            smp_ev = (cke == sample_phase);
          end
          if (s_reg.half == 6'h01 && fdly) begin
            s_next.fs = 1'b0;
          end
        end else begin
          // tail half period, last end-of-bit sample
          smp_ev = !cke && sample_phase;
          done = 1'b1;
          s_next.busy = 1'b0;
          s_next.half = 6'h00;
        end
      end else begin
        s_next.divc = s_reg.divc + 10'h001;
      end
    end else if (run) begin
      // slave: preload when between words and no edge now
      if (!s_reg.busy && s_reg.bitn == 5'h00 && s_reg.txf &&
          !lead && !trail) begin
        s_next.busy = 1'b1;
        s_next.txf = 1'b0;
        s_next.sr = cke ? {s_reg.txh[14:0], 1'b0} : s_reg.txh;
        if (cke) begin
          s_next.sdo = s_reg.txh[msb];
        end
      end
      if (fen && s_reg.ss2 == fpol) begin
        s_next.armed = 1'b1;
      end
      if (!fen && slave_select_enable && s_reg.ss2) begin
        s_next.bitn = 5'h00;
      end else if (!fen || s_reg.armed) begin
        // far party supplies the clock
        if (lead) begin
          chg = !cke;
          smp_ev = cke;
        end
        if (trail) begin
          chg = cke;
          smp_ev = !cke;
        end
      end
      if (smp_ev) begin
        if (s_reg.bitn == nbits - 5'h01) begin
          done = 1'b1;
          s_next.bitn = 5'h00;
          s_next.busy = 1'b0;
          s_next.armed = 1'b0;
        end else begin
          s_next.bitn = s_reg.bitn + 5'h01;
        end
      end
    end
    // shift out and shift in
    if (chg) begin
      s_next.sdo = s_reg.sr[msb];
      s_next.sr = {s_reg.sr[14:0], 1'b0};
    end
    if (smp_ev) begin
      s_next.rxs = {s_reg.rxs[14:0], s_reg.sdi2};
    end
    // hand completed word to receive holding
    if (done) begin
      if (s_next.rxf || s_reg.ovf) begin
        s_next.ovf = 1'b1;
      end else begin
        s_next.rxh = wide ? s_next.rxs : {8'h00, s_next.rxs[7:0]};
        s_next.rxf = 1'b1;
      end
    end
    // register writes, tx write set wins over load clear
    if (apb_acc && pwrite) begin
      case (paddr)
        `SPMS_STAT_OFS: begin
          s_next.stat = pwdata[15:0] & `SPMS_STAT_WMASK;
        end
        `SPMS_CON1_OFS: begin
          s_next.con1 = pwdata[15:0] & `SPMS_CON1_WMASK;
        end
        `SPMS_CON2_OFS: begin
          s_next.con2 = pwdata[15:0] & `SPMS_CON2_WMASK;
        end
        `SPMS_BUF_OFS: begin
          s_next.txh = pwdata[15:0];
          s_next.txf = 1'b1;
        end
        default: begin
          s_next.txf = s_next.txf;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // ---------------------------------------------------------------
  // pin drive
  // ---------------------------------------------------------------
  assign link_out.sck_o = s_reg.sck;
  assign link_out.sck_oe = en && master && !clkdis;
  assign link_out.sdo_o = s_reg.sdo;
  assign link_out.sdo_oe = en && !dodis &&
    (master || fen || !slave_select_enable || !s_reg.ss2);
  assign link_out.ss_o = s_reg.fs ? fpol : !fpol;
  assign link_out.ss_oe = en && master && fen && !fdir;

endmodule

// ==== sim/spms_port_assertions.sv ====
// assertion checker bound to the serial port
`timescale 1ns/1ps
`include "spms_defines.svh"

module spms_port_assertions
  import spms_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // device state and link
  input wire logic idle_mode,
  input wire logic ss_n_i,
  input wire spms_pin_out_t link_out
);
  // --------
  // shadow of written control bits
  // --------
  logic [15:0] st_reg;
  logic [15:0] c1_reg;
  logic fen_reg;
  logic [15:0] win_reg;
  logic [31:0] k;
  logic wr;
  logic mst;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // half period in pclk cycles, write strobe, master enabled
  assign k = (32'h1 << (32'h2 * (32'h3 - c1_reg[1:0]))) *
    (32'h8 - c1_reg[4:2]);
  assign wr = psel && penable && pwrite;
  assign mst = st_reg[15] && c1_reg[5];

  // window of cycles in which a loaded word may clock out
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= 16'h0000;
      c1_reg <= 16'h0000;
      fen_reg <= 1'b0;
      win_reg <= 16'h0000;
    end else begin
      if (wr && paddr == `SPMS_STAT_OFS) st_reg <= pwdata[15:0];
      if (wr && paddr == `SPMS_CON1_OFS) c1_reg <= pwdata[15:0];
      if (wr && paddr == `SPMS_CON2_OFS) fen_reg <= pwdata[15];
      if (wr && paddr == `SPMS_BUF_OFS)
        win_reg <= win_reg + k[15:0] * 16'h23 + 16'h2;
      else if (mst && !c1_reg[12] && !(st_reg[13] && idle_mode) && |win_reg)
        win_reg <= win_reg - 16'h1;
    end
  end

  AST_READY: assert property (psel && penable |-> pready)
    else $error("access phase without ready");
  AST_UNMAPPED: assert property (psel && penable && paddr > 8'h0C
    |-> pslverr && prdata == 32'h0) else $error("unmapped access accepted");
  AST_UPPER_ZERO: assert property (prdata[31:16] == 16'h0000)
    else $error("upper read bits not zero");
  AST_CLOCK_DRIVE: assert property (
    link_out.sck_oe == (mst && !c1_reg[12]))
    else $error("clock pin drive wrong");
  AST_DATA_DRIVE: assert property (
    mst |-> link_out.sdo_oe == !c1_reg[11])
    else $error("data pin drive wrong");
  AST_DISABLED: assert property (
    !st_reg[15] |-> !(link_out.sck_oe || link_out.sdo_oe))
    else $error("disabled port drives pins");
  AST_START: assert property ($rose(link_out.sck_o) && mst && !c1_reg[6]
    |-> win_reg != 16'h0000) else $error("clock without loaded word");
  AST_SELECT: assert property (
    st_reg[15] && !c1_reg[5] && c1_reg[7] && !fen_reg
    && ss_n_i && $past(ss_n_i) && $past(ss_n_i, 2) && $past(ss_n_i, 3)
    |-> !link_out.sdo_oe) else $error("deselected slave drives data");

  cover property (psel && penable && pslverr);
  cover property ($rose(link_out.sck_o));
  cover property (!ss_n_i ##1 ss_n_i);
endmodule

bind spms_port spms_port_assertions u_chk (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .idle_mode, .ss_n_i,
  .link_out);

// ==== sim/spms_far_model.sv ====
// far-side device model on the serial link
`timescale 1ns/1ps

module spms_far_model (
  // pins seen
  input wire logic sck_pin,
  input wire logic sdo_pin,
  // pins driven
  output logic sck_out,
  output logic sdi_out,
  output logic ss_n_out
);
  // --------
  // shift logic
  // --------
  logic [15:0] tx_word = 16'h0000;
  logic [15:0] rx_word = 16'h0000;
  int bits = 8;

  // sample on leading edge, change on trailing edge, msb first
  always @(posedge sck_pin) rx_word <= {rx_word[14:0], sdo_pin};
  always @(negedge sck_pin) tx_word <= {tx_word[14:0], ~tx_word[0]};
  assign sdi_out = tx_word[bits - 1];

  // clock stands still and select high outside frames
  initial begin
    sck_out = 1'b0;
    ss_n_out = 1'b1;
  end

  // clock source for a slave port: one selected word, 32 ns period
  task automatic send(input logic [15:0] w, input int n);
    tx_word = w;
    bits = n;
    ss_n_out = 1'b0;
    repeat (n) begin
      #16 sck_out = 1'b1;
      #16 sck_out = 1'b0;
    end
    #16 ss_n_out = 1'b1;
  endtask
endmodule

// ==== sim/test_spi_master_slave_port.sv ====
// self-checking bench for the serial port
`timescale 1ns/1ps
`include "spms_defines.svh"

module test_spi_master_slave_port;
  // --------
  // signals
  // --------
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic idle_mode = 1'b0;
  logic tgl = 1'b0;
  logic sck_q = 1'b0;
  logic e;
  logic [31:0] r;
  logic [15:0] q[$];
  logic [2:0] sec [4] = '{3'h7, 3'h6, 3'h0, 3'h5};
  spms_pkg::spms_pin_out_t link_out;
  wire far_sck, far_sdi, far_ss_n;
  wire sck_w = link_out.sck_oe ? link_out.sck_o : far_sck;
  wire sdo_w = link_out.sdo_oe ? link_out.sdo_o : tgl;
  int fail_count = 0;
  int checked = 0;
  int cyc = 0;
  int rises = 0;
  int first_c = 0;
  int last_c = 0;
  int fsc = 0;

  spms_port dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .idle_mode, .sck_i(sck_w), .sdi_i(far_sdi),
    .ss_n_i(far_ss_n), .link_out);
  spms_far_model far (.sck_pin(sck_w), .sdo_pin(sdo_w), .sck_out(far_sck),
    .sdi_out(far_sdi), .ss_n_out(far_ss_n));

  // 250 MHz clock
  initial forever #2 pclk = ~pclk;

  // released data line toggles; clock rises timed in pclk cycles
  always @(posedge pclk) begin
    tgl <= ~tgl;
    cyc <= cyc + 1;
    sck_q <= link_out.sck_o;
    // cycles with the frame sync pin driven active
    if (link_out.ss_oe && link_out.ss_o) begin
      fsc <= fsc + 1;
    end
    if (link_out.sck_o && !sck_q) begin
      rises <= rises + 1;
      last_c <= cyc;
      if (rises == 0) first_c <= cyc;
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one apb transfer, setup then access until ready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(r, exp);
  endtask

  task automatic poll(input logic [15:0] m);
    r = 32'h0;
    while ((r[15:0] & m) == 16'h0) apb(1'b0, `SPMS_STAT_OFS, 32'h0);
  endtask

  task automatic finish_test;
    $display("checked %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // watchdog, far beyond the few thousand cycles the scenarios need
  initial begin
    #200000;
    fail_count++;
    finish_test;
  end

  // --------
  // scenarios
  // --------
  initial begin
    int k;
    int n;
    logic [15:0] w;
    logic [15:0] fw;
    logic [15:0] c;
    logic [15:0] m;
    void'($urandom(32'h9765));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(`SPMS_STAT_OFS, 32'h0);
    rd(`SPMS_CON1_OFS, 32'h0);
    rd(8'h10, 32'h0);
    chk(e, 32'h1);
    w = 16'($urandom) & 16'hFDFF;
    apb(1'b1, `SPMS_CON1_OFS, {16'h0, w});
    rd(`SPMS_CON1_OFS, {16'h0, w & `SPMS_CON1_WMASK});
    apb(1'b1, `SPMS_STAT_OFS, 32'hFFFF);
    rd(`SPMS_STAT_OFS, 32'hA000);
    apb(1'b1, `SPMS_STAT_OFS, 32'h8000);
    // master words over every primary code and both widths
    for (int i = 0; i < 4; i++) begin
      n = i[0] ? 16 : 8;
      m = i[0] ? 16'hFFFF : 16'h00FF;
      k = (1 << (2 * (3 - i))) * (8 - sec[i]);
      c = 16'h1120 | (16'(i[0]) << 10) | (16'(sec[i]) << 2) | 16'(i);
      w = 16'($urandom);
      fw = 16'($urandom);
      q.push_back(fw & m);
      apb(1'b1, `SPMS_CON1_OFS, {16'h0, c});
      // load far word only after the clock pin has settled
      far.tx_word = fw;
      far.bits = n;
      apb(1'b1, `SPMS_BUF_OFS, {16'h0, w});
      rd(`SPMS_STAT_OFS, 32'h8002);
      rises = 0;
      apb(1'b1, `SPMS_CON1_OFS, {16'h0, c & 16'hEFFF});
      poll(16'h0001);
      chk(rises, n);
      chk(last_c - first_c, (n - 1) * 2 * k);
      chk(far.rx_word & m, w & m);
      rd(`SPMS_BUF_OFS, q.pop_front());
      rd(`SPMS_STAT_OFS, 32'h8000);
    end
    // two words back to back; the second finds the receive side full
    w = 16'($urandom);
    fw = 16'($urandom);
    far.tx_word = fw;
    apb(1'b1, `SPMS_BUF_OFS, 32'h1234);
    apb(1'b1, `SPMS_BUF_OFS, {16'h0, w});
    poll(16'h0040);
    chk(far.rx_word, w);
    rd(`SPMS_BUF_OFS, {16'h0, fw});
    rd(`SPMS_STAT_OFS, 32'h8040);
    apb(1'b1, `SPMS_STAT_OFS, 32'h8000);
    rd(`SPMS_STAT_OFS, 32'h8000);
    // idle with idle_stop set holds the engine
    apb(1'b1, `SPMS_STAT_OFS, 32'hA000);
    idle_mode <= 1'b1;
    rises = 0;
    far.tx_word = fw;
    apb(1'b1, `SPMS_BUF_OFS, {16'h0, w});
    repeat (200) @(posedge pclk);
    chk(rises, 0);
    idle_mode <= 1'b0;
    poll(16'h0001);
    chk(rises, 16);
    rd(`SPMS_BUF_OFS, {16'h0, fw});
    // framed master: sync output one half period (3 cycles) ahead
    apb(1'b1, `SPMS_CON2_OFS, 32'hA000);
    fsc = 0;
    rises = 0;
    apb(1'b1, `SPMS_BUF_OFS, {16'h0, w});
    poll(16'h0001);
    chk(fsc, 32'h3);
    chk(rises, 32'h10);
    apb(1'b0, `SPMS_BUF_OFS, 32'h0);
    apb(1'b1, `SPMS_CON2_OFS, 32'h0);
    // slave word clocked by the far side with select in use
    apb(1'b1, `SPMS_CON1_OFS, 32'h0180);
    apb(1'b1, `SPMS_STAT_OFS, 32'h8000);
    apb(1'b1, `SPMS_BUF_OFS, {16'h0, w});
    repeat (8) @(posedge pclk);
    far.send(fw, 8);
    @(posedge pclk);
    poll(16'h0001);
    rd(`SPMS_BUF_OFS, {24'h0, fw[7:0]});
    chk(far.rx_word[7:0], w[7:0]);
    // idle clock level follows polarity
    apb(1'b1, `SPMS_CON1_OFS, 32'h0060);
    @(negedge pclk);
    chk(link_out.sck_o, 32'h1);
    @(posedge pclk);
    finish_test;
  end
endmodule
